// *** inc/scb_params.svh ***
// constants for the serial command byte front end and its host controller
// assumes inclusion by bare name from the package and both design files
`ifndef SCB_PARAMS_SVH
`define SCB_PARAMS_SVH

// command byte layout, first-sent bit is bit 7
`define SCB_CMD_BITS      8
`define SCB_CR_WEN        7
`define SCB_CR_KIND_HI    5
`define SCB_CR_KIND_LO    4
`define SCB_CR_SEL_HI     2
`define SCB_CR_SEL_LO     0
`define SCB_SEL_CMD_REG   3'h0

// access kinds
`define SCB_KIND_WRITE    2'h0
`define SCB_KIND_READ     2'h1
`define SCB_KIND_CONT     2'h2
`define SCB_KIND_STOP     2'h3

// continuous read exit byte, all-ones resync length and longest data word in bits
`define SCB_EXIT_BYTE     8'h30
`define SCB_ONES_RESET    32
`define SCB_MAX_BITS      24

// host register map (byte addresses) and fields
`define SCB_A_CMD         8'h00
`define SCB_A_WDATA       8'h04
`define SCB_A_RDATA       8'h08
`define SCB_A_STATUS      8'h0c
`define SCB_A_CTRL        8'h10
`define SCB_F_NBITS_LO    8
`define SCB_F_NOCMD       13
`define SCB_F_RESYNC      14
`define SCB_ST_BUSY       0
`define SCB_ST_CONT       1
`define SCB_CT_LINK_RST   0

// host serial clock divider: aclk cycles per half period
`define SCB_HALF_DIV      4

`define SCB_RESP_OKAY     2'h0
`define SCB_RESP_SLVERR   2'h2

`endif

// *** inc/scb_pkg.sv ***
// types shared by both ends of the serial command byte link
// assumes scb_params.svh is on the include path
`include "scb_params.svh"

package scb_pkg;
    typedef enum logic [1:0] {
        DEV_CMD,
        DEV_WR,
        DEV_RD,
        DEV_CONT
    } scb_dev_state_t;

    typedef logic [1:0] scb_kind_t;
    typedef logic [2:0] scb_sel_t;
endpackage

// *** inc/scb_if.sv ***
// serial link between the host controller and the command byte front end
// assumes the bench resolves nothing: all wires are point to point
`timescale 1ns/1ns
`default_nettype none

interface scb_if;
    logic sclk;
    logic din;
    logic dout;
    logic link_rst_n;

    modport host (
        output sclk,
        output din,
        output link_rst_n,
        input  dout
    );

    modport device (
        input  sclk,
        input  din,
        input  link_rst_n,
        output dout
    );
endinterface

`default_nettype wire

// *** design/scb_device.sv ***
// device end: command byte interpreter clocked by the link serial clock
// assumes the back end answers ask_sel with rd_word and xfer_bits in the same cycle
`timescale 1ns/1ns
`default_nettype none
`include "scb_params.svh"

//  Overview of operation
// RQ1: every transaction opens with a command byte
// RQ2: command byte picks direction, read kind, target
// RQ3: single transfers return to command wait
// RQ4: reset leaves interface awaiting command byte
// RQ5: 32 high clocks on data-in reset
// RQ6: command byte shifts in bit seven first
// RQ7: host sends zero in write gate bit
// RQ8: gate bit high holds first position
// RQ9: host always sends zero in bit six
// RQ10: bits five and four give access kind
// RQ11: target select zero is command register
// RQ12: kinds: write, read, start, stop continuous
// RQ13: byte 30 hex leaves continuous reads
// RQ14: data-in sampled every edge in continuous
// RQ15: low three bits select target register
// RQ16: ones counter restarts on any low sample
module scb_device
    import scb_pkg::*;
(
    // link
    scb_if.device                link,
    // clock enable, link clock domain
    input  wire logic            ce,
    // register back end
    output logic     [2:0]       ask_sel,
    input  wire logic [4:0]      xfer_bits,
    input  wire logic [23:0]     rd_word,
    output logic     [2:0]       sel_reg,
    output logic     [1:0]       kind_reg,
    output logic     [23:0]      wr_word_reg,
    output logic                 wr_pulse_reg,
    output logic                 rd_pulse_reg,
    output logic                 cont_reg,
    output logic                 soft_reset_reg
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    scb_dev_state_t  state_reg;
    scb_dev_state_t  state_next;
    logic [2:0]      bcnt_reg;
    logic [6:0]      csh_reg;
    logic [4:0]      dcnt_reg;
    logic [4:0]      len_reg;
    logic [23:0]     sh_reg;
    logic [23:0]     wsh_reg;
    logic [2:0]      xcnt_reg;
    logic [6:0]      xsh_reg;
    logic [5:0]      ones_reg;
    logic            dout_reg;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic [23:0] align_msb(input logic [23:0] w, input logic [4:0] n);
        logic [4:0] sh;
        sh = 5'(`SCB_MAX_BITS) - n;
        align_msb = w << sh;
    endfunction

    wire        din      = link.din;
    wire [7:0]  cmd_byte = {csh_reg, din};                          // RQ6
    wire [1:0]  cmd_kind = cmd_byte[`SCB_CR_KIND_HI:`SCB_CR_KIND_LO]; // RQ10
    wire [2:0]  cmd_sel  = cmd_byte[`SCB_CR_SEL_HI:`SCB_CR_SEL_LO];   // RQ15
    wire        sel_cmd  = (cmd_sel == `SCB_SEL_CMD_REG);           // RQ11
    wire        gate_hold = (bcnt_reg == 3'h0) && din;              // RQ8
    wire        cmd_done = (state_reg == DEV_CMD) && !gate_hold && (bcnt_reg == 3'h7);
    wire        word_end = (dcnt_reg == (len_reg - 5'h1));
    wire [7:0]  exit_byte = {xsh_reg, din};
    wire        exit_hit = (state_reg == DEV_CONT) && (xcnt_reg == 3'h7)
                           && (exit_byte == `SCB_EXIT_BYTE);        // RQ13
    wire        ones_hit = din && (ones_reg == 6'(`SCB_ONES_RESET - 1)); // RQ5
    wire        go_wr    = cmd_done && (cmd_kind == `SCB_KIND_WRITE) && !sel_cmd;
    wire        go_rd    = cmd_done && (cmd_kind == `SCB_KIND_READ) && !sel_cmd;
    wire        go_cont  = cmd_done && (cmd_kind == `SCB_KIND_CONT) && !sel_cmd;
    wire        load_rd  = go_rd || go_cont || ((state_reg == DEV_CONT) && word_end && !exit_hit);
    wire [23:0] rd_al    = align_msb(rd_word, xfer_bits);

    assign ask_sel   = (state_reg == DEV_CMD) ? cmd_sel : sel_reg;
    assign link.dout = dout_reg;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DEV_CMD: begin
                // only a command byte leads anywhere else
                if (go_wr) begin // RQ1
                    state_next = DEV_WR; // RQ2
                end else if (go_rd) begin
                    state_next = DEV_RD; // RQ2
                end else if (go_cont) begin
                    state_next = DEV_CONT; // RQ12
                end
            end
            DEV_WR: begin
                if (word_end) begin
                    state_next = DEV_CMD; // RQ3
                end
            end
            DEV_RD: begin
                if (word_end) begin
                    state_next = DEV_CMD; // RQ3
                end
            end
            DEV_CONT: begin
                // stays until the exit byte or a ones resync; no command bytes in between
                if (exit_hit) begin
                    state_next = DEV_CMD; // RQ13
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    wire rst = !link.link_rst_n || (ce && ones_hit);

    always_ff @(posedge link.sclk) begin
        if (!link.link_rst_n) begin
            state_reg <= DEV_CMD; // RQ4
            bcnt_reg  <= 3'h0;
            csh_reg   <= 7'h00;
        end else if (ce) begin
            if (ones_hit) begin
                state_reg <= DEV_CMD; // RQ5
                bcnt_reg  <= 3'h0;
            end else begin
                state_reg <= state_next;
                if (state_reg == DEV_CMD && !gate_hold) begin
                    bcnt_reg <= bcnt_reg + 3'h1;
                    csh_reg  <= {csh_reg[5:0], din}; // RQ6
                end
            end
        end
    end

    // ones detector sees every edge in every state
    always_ff @(posedge link.sclk) begin
        if (!link.link_rst_n) begin
            ones_reg <= 6'h00;
        end else if (ce) begin
            ones_reg <= (!din || ones_hit) ? 6'h00 : ones_reg + 6'h1; // RQ16
        end
    end

    // command capture and word counters
    always_ff @(posedge link.sclk) begin
        if (rst) begin
            sel_reg  <= 3'h0;
            kind_reg <= 2'h0;
            len_reg  <= 5'h0;
            dcnt_reg <= 5'h0;
            cont_reg <= 1'b0;
        end else if (ce) begin
            if (cmd_done) begin
                sel_reg  <= cmd_sel;  // RQ2
                kind_reg <= cmd_kind;
                len_reg  <= xfer_bits;
                dcnt_reg <= 5'h0;
            end else if (state_reg != DEV_CMD) begin
                dcnt_reg <= word_end ? 5'h0 : dcnt_reg + 5'h1;
            end
            if (go_cont) begin
                cont_reg <= 1'b1;
            end else if (exit_hit) begin
                cont_reg <= 1'b0;
            end
        end
    end

    // byte-aligned watch on data-in while reads repeat
    always_ff @(posedge link.sclk) begin
        if (rst || !cont_reg) begin
            xcnt_reg <= 3'h0;
            xsh_reg  <= 7'h00;
        end else if (ce) begin
            xcnt_reg <= xcnt_reg + 3'h1; // RQ14
            xsh_reg  <= {xsh_reg[5:0], din}; // RQ14
        end
    end

    // ------------------------------------------------------------
    // data shifting
    // ------------------------------------------------------------
    always_ff @(posedge link.sclk) begin
        if (rst) begin
            sh_reg       <= 24'h000000;
            wsh_reg      <= 24'h000000;
            wr_word_reg  <= 24'h000000;
            wr_pulse_reg <= 1'b0;
            rd_pulse_reg <= 1'b0;
            dout_reg     <= 1'b0;
        end else if (ce) begin
            wr_pulse_reg <= 1'b0;
            rd_pulse_reg <= load_rd;
            if (load_rd) begin
                // first read bit must be on the pin before the next edge
                sh_reg   <= rd_al;
                dout_reg <= rd_al[23];
            end else if (state_reg == DEV_RD || state_reg == DEV_CONT) begin
                sh_reg   <= {sh_reg[22:0], 1'b0};
                dout_reg <= sh_reg[22];
            end else begin
                dout_reg <= 1'b0;
            end
            if (cmd_done) begin
                wsh_reg <= 24'h000000;
            end else if (state_reg == DEV_WR) begin
                wsh_reg <= {wsh_reg[22:0], din};
                if (word_end) begin
                    wr_word_reg  <= {wsh_reg[22:0], din};
                    wr_pulse_reg <= 1'b1;
                end
            end
        end
    end

    // back end is told about resync so it can restore its own defaults
    always_ff @(posedge link.sclk) begin
        if (!link.link_rst_n) begin
            soft_reset_reg <= 1'b0;
        end else if (ce) begin
            soft_reset_reg <= ones_hit;
        end
    end

endmodule

`default_nettype wire

// *** design/scb_host.sv ***
// host end: axi4-lite controlled serial master that makes the link clock
// assumes software waits for busy to clear before issuing the next frame
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "scb_params.svh"

module scb_host
    import scb_pkg::*;
#(
    parameter int HALF_DIV = `SCB_HALF_DIV
)(
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // link
    scb_if.host              link
);

    // ------------------------------------------------------------
    // axi slave
    // ------------------------------------------------------------
    logic [7:0]  awa_reg;
    logic        aw_got_reg;
    logic [31:0] wd_reg;
    logic [3:0]  ws_reg;
    logic        w_got_reg;
    logic [23:0] wdata_reg;
    logic [23:0] rdata_reg;
    logic        run_reg;
    logic        cont_reg;
    logic        lrst_reg;

    wire do_wr  = aw_got_reg && w_got_reg && !s_axi_bvalid;
    wire a_cmd  = (awa_reg == `SCB_A_CMD);
    wire a_wd   = (awa_reg == `SCB_A_WDATA);
    wire a_ct   = (awa_reg == `SCB_A_CTRL);
    wire start  = do_wr && a_cmd && !run_reg && (ws_reg[1:0] == 2'h3);
    wire wr_ok  = start || a_wd || a_ct;
    wire [31:0] status = {30'h0, cont_reg, run_reg};
    wire [31:0] rd_mux = (s_axi_araddr == `SCB_A_RDATA)  ? {8'h00, rdata_reg} :
                         (s_axi_araddr == `SCB_A_WDATA)  ? {8'h00, wdata_reg} :
                         (s_axi_araddr == `SCB_A_STATUS) ? status :
                         {31'h0, lrst_reg};
    wire rd_map = (s_axi_araddr == `SCB_A_RDATA) || (s_axi_araddr == `SCB_A_WDATA)
                  || (s_axi_araddr == `SCB_A_STATUS) || (s_axi_araddr == `SCB_A_CTRL);

    assign s_axi_awready = !aw_got_reg;
    assign s_axi_wready  = !w_got_reg;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            awa_reg      <= 8'h00;
            wd_reg       <= 32'h0;
            ws_reg       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SCB_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `SCB_RESP_OKAY;
            s_axi_rdata  <= 32'h0;
            wdata_reg    <= 24'h000000;
            lrst_reg     <= 1'b0;
        end else if (ce) begin
            if (s_axi_awvalid && !aw_got_reg) begin
                aw_got_reg <= 1'b1;
                awa_reg    <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_got_reg) begin
                w_got_reg <= 1'b1;
                wd_reg    <= s_axi_wdata;
                ws_reg    <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // a frame request while busy is refused, not queued
                s_axi_bresp  <= wr_ok ? `SCB_RESP_OKAY : `SCB_RESP_SLVERR;
                if (a_wd) begin
                    for (int i = 0; i < 3; i++) begin
                        if (ws_reg[i]) begin
                            wdata_reg[8*i +: 8] <= wd_reg[8*i +: 8];
                        end
                    end
                end
                if (a_ct && ws_reg[0]) begin
                    lrst_reg <= wd_reg[`SCB_CT_LINK_RST];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_map ? rd_mux : 32'h0;
                s_axi_rresp  <= rd_map ? `SCB_RESP_OKAY : `SCB_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------
    logic [7:0]  ph_reg;
    logic        sclk_reg;
    logic        din_reg;
    logic [31:0] osh_reg;
    logic [5:0]  left_reg;
    logic [4:0]  nb_reg;
    logic [23:0] ish_reg;
    logic        dout_s1_reg;
    logic        dout_s2_reg;

    wire        rise_evt = (ph_reg == 8'(HALF_DIV - 1));
    wire        fall_evt = (ph_reg == 8'(2*HALF_DIV - 1));
    wire [4:0]  nbits    = wd_reg[`SCB_F_NBITS_LO +: 5];
    wire        nocmd    = wd_reg[`SCB_F_NOCMD];
    wire        resync   = wd_reg[`SCB_F_RESYNC];
    wire [7:0]  cmd      = wd_reg[7:0];
    wire [1:0]  kind     = cmd[`SCB_CR_KIND_HI:`SCB_CR_KIND_LO];
    wire        is_wr    = !nocmd && (kind == `SCB_KIND_WRITE);
    wire [23:0] out_data = is_wr ? (wdata_reg << (5'(`SCB_MAX_BITS) - nbits)) : 24'h000000;
    wire [23:0] rmask    = ~(24'hffffff << nb_reg);
    logic        start_p_reg;

    assign link.sclk       = sclk_reg;
    assign link.din        = din_reg;
    assign link.link_rst_n = !lrst_reg && aresetn;

    // dout comes back from the other clock domain
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dout_s1_reg <= 1'b0;
            dout_s2_reg <= 1'b0;
        end else if (ce) begin
            dout_s1_reg <= link.dout;
            dout_s2_reg <= dout_s1_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ph_reg      <= 8'h00;
            sclk_reg    <= 1'b0;
            din_reg     <= 1'b1;
            osh_reg     <= 32'h0;
            left_reg    <= 6'h00;
            nb_reg      <= 5'h00;
            ish_reg     <= 24'h000000;
            rdata_reg   <= 24'h000000;
            run_reg     <= 1'b0;
            cont_reg    <= 1'b0;
            start_p_reg <= 1'b0;
        end else if (ce) begin
            ph_reg <= fall_evt ? 8'h00 : ph_reg + 8'h01;
            // clock runs only inside frames and while the link reset is held
            if (rise_evt && (run_reg || lrst_reg)) begin
                sclk_reg <= 1'b1;
                ish_reg  <= {ish_reg[22:0], dout_s2_reg};
            end else if (fall_evt) begin
                sclk_reg <= 1'b0;
            end
            if (start) begin
                start_p_reg <= 1'b1;
                nb_reg      <= resync ? 5'h00 : nbits;
                if (resync) begin
                    osh_reg  <= 32'hffffffff; // RQ5
                    left_reg <= 6'(`SCB_ONES_RESET);
                    cont_reg <= 1'b0;
                end else if (nocmd) begin
                    osh_reg  <= 32'h0; // RQ14
                    left_reg <= {1'b0, nbits};
                end else begin
                    osh_reg  <= {cmd & 8'h7f & 8'hbf, out_data}; // RQ7 RQ9
                    left_reg <= 6'(`SCB_CMD_BITS) + {1'b0, nbits}; // RQ1
                    if (kind == `SCB_KIND_CONT) begin
                        cont_reg <= 1'b1;
                    end else if (cmd == `SCB_EXIT_BYTE) begin
                        cont_reg <= 1'b0; // RQ13
                    end
                end
            end
            if (fall_evt) begin
                if (start_p_reg) begin
                    start_p_reg <= 1'b0;
                    run_reg     <= 1'b1;
                    din_reg     <= osh_reg[31]; // RQ6
                    osh_reg     <= {osh_reg[30:0], 1'b0};
                    left_reg    <= left_reg - 6'h01;
                end else if (run_reg && left_reg != 6'h00) begin
                    din_reg  <= osh_reg[31];
                    osh_reg  <= {osh_reg[30:0], 1'b0};
                    left_reg <= left_reg - 6'h01;
                end else if (run_reg) begin
                    run_reg   <= 1'b0;
                    din_reg   <= !cont_reg; // RQ14
                    rdata_reg <= ish_reg & rmask;
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** sim/scb_properties.sv ***
// link checker for the command byte front end
// assumes the bench wires it beside scb_if with the device state ports
`timescale 1ns/1ns
`default_nettype none
module scb_properties (
    // link
    input wire logic       sclk,
    input wire logic       din,
    input wire logic       link_rst_n,
    // device state
    input wire logic [2:0] sel_reg,
    input wire logic [1:0] kind_reg,
    input wire logic       cont_reg,
    input wire logic       wr_pulse_reg,
    input wire logic       rd_pulse_reg,
    input wire logic       soft_reset_reg
);
    logic [7:0]      sh;
    logic [2:0]      pos;
    logic [5:0]      ones;
    wire logic [7:0] byte_now = {sh[6:0], din};

    default clocking cb @(posedge sclk); endclocking
    default disable iff (!link_rst_n);

    // byte phase counts from the decode edge so exit bytes line up
    always_ff @(posedge sclk) begin
        sh  <= byte_now;
        pos <= cont_reg ? pos + 3'h1 : 3'h0;
        if (!link_rst_n || !din) begin
            ones <= 6'h0;
        end else if (ones != 6'h20) begin
            ones <= ones + 6'h1;
        end
    end

    sequence exit_seen;
        cont_reg && pos == 3'h7 && byte_now == 8'h30;
    endsequence
    sequence cmd_loaded;
        ($changed(sel_reg) || $changed(kind_reg)) && sh != 8'hff;
    endsequence

    a_cmd_msb_first: assert property (cmd_loaded |-> sh[7:6] == 2'h0
        && sh[5:4] == kind_reg && sh[2:0] == sel_reg) else $error("command fields wrong");
    a_ones_reach: assert property (ones == 6'h1f && din |=> soft_reset_reg)
        else $error("no resync after ones");
    a_ones_cause: assert property (soft_reset_reg |-> ones == 6'h20)
        else $error("resync without full ones run");
    a_cont_exit: assert property (exit_seen |=> !cont_reg)
        else $error("exit byte ignored");
    a_cont_start: assert property ($rose(cont_reg) |-> kind_reg == 2'h2
        && sel_reg != 3'h0) else $error("continuous mode without start command");
    a_wr_kind: assert property (wr_pulse_reg |-> kind_reg == 2'h0 && !cont_reg)
        else $error("write word on non write command");
    a_rd_kind: assert property (rd_pulse_reg |-> kind_reg inside {2'h1, 2'h2})
        else $error("read word on non read command");
    a_wr_single: assert property (wr_pulse_reg |=> !wr_pulse_reg [*8])
        else $error("second write without command");
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench: host and device ends joined by scb_if
// assumes design files, scb_pkg and scb_params.svh compiled first
`timescale 1ns/1ns
`default_nettype none
`include "scb_params.svh"
module tb;
    localparam int HD = 4;
    logic        aclk, aresetn, ce;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, kind_reg, rr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [2:0]  ask_sel, sel_reg, s;
    logic [4:0]  xfer_bits;
    logic [23:0] rd_word, wr_word_reg, rd_base;
    logic        wr_pulse_reg, rd_pulse_reg, cont_reg, soft_reset_reg;
    int          err_count, checks_done;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // widths 8/16/24 keep continuous words byte aligned
    function automatic logic [4:0] nb(logic [2:0] x);
        return 5'(8 * (1 + x % 3));
    endfunction
    function automatic logic [23:0] msk(logic [23:0] w, logic [4:0] n);
        return w & ((24'h1 << n) - 24'h1);
    endfunction
    function automatic logic [31:0] cmdw(logic [1:0] k, logic [2:0] x, logic [4:0] n,
                                         logic [1:0] f);
        return {17'h0, f, n, 2'h0, k, 1'b0, x};
    endfunction

    scb_if link ();
    scb_host #(.HALF_DIV(HD)) i_scb_host (.*);
    scb_device i_scb_device (.*);
    scb_properties i_scb_properties (.sclk(link.sclk), .din(link.din),
                                     .link_rst_n(link.link_rst_n), .*);
    assign xfer_bits = nb(ask_sel);
    assign rd_word   = rd_base ^ 24'(ask_sel);
    always #4 aclk = ~aclk;

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        chk(rr, er);
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // busy rises late, so wait to see it high before waiting for it low
    task automatic frame(logic [31:0] c);
        logic [31:0] st;
        wr(`SCB_A_CMD, c, `SCB_RESP_OKAY);
        do rd(`SCB_A_STATUS, st); while (!st[0]);
        do rd(`SCB_A_STATUS, st); while (st[0]);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        ce = 1'b1;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rd_base} = '0;
        void'($urandom(32'h6323f3ae));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        wr(`SCB_A_CTRL, 32'h1, `SCB_RESP_OKAY);
        repeat (40 * HD) @(posedge aclk);
        wr(`SCB_A_CTRL, 32'h0, `SCB_RESP_OKAY);
        chk({cont_reg, kind_reg, sel_reg, link.dout}, 32'h0);
        rd(`SCB_A_STATUS, v);
        chk(v, 32'h0);
        rd(8'h14, v);
        chk(rr, `SCB_RESP_SLVERR);
        wr(`SCB_A_RDATA, 32'h0, `SCB_RESP_SLVERR);
        $display("test idle done");
        frame(cmdw(2'h0, 3'h0, 5'h0, 2'h0));
        frame(cmdw(2'h3, 3'h5, 5'h0, 2'h0));
        for (int i = 0; i < 6; i++) begin
            s = 3'($urandom_range(7, 1));
            v = $urandom;
            wr(`SCB_A_WDATA, v, `SCB_RESP_OKAY);
            frame(cmdw(2'h0, s, nb(s), 2'h0));
            chk(wr_word_reg, msk(v[23:0], nb(s)));
            chk({kind_reg, sel_reg}, {2'h0, s});
        end
        $display("test writes done");
        for (int i = 0; i < 4; i++) begin
            s = 3'($urandom_range(7, 1));
            rd_base <= 24'($urandom);
            frame(cmdw(2'h1, s, nb(s), 2'h0));
            rd(`SCB_A_RDATA, v);
            chk(v, msk(rd_base ^ 24'(s), nb(s)));
        end
        $display("test reads done");
        s = 3'($urandom_range(7, 1));
        rd_base <= 24'($urandom);
        frame(cmdw(2'h2, s, nb(s), 2'h0));
        rd(`SCB_A_STATUS, v);
        chk({v[1], cont_reg}, 2'b11);
        for (int i = 0; i < 2; i++) begin
            rd(`SCB_A_RDATA, v);
            chk(v, msk(rd_base ^ 24'(s), nb(s)));
            if (i == 0) frame(cmdw(2'h0, 3'h0, nb(s), 2'h1));
        end
        frame(cmdw(2'h3, 3'h0, 5'h0, 2'h0));
        chk(cont_reg, 1'b0);
        frame(cmdw(2'h0, 3'h0, 5'h0, 2'h2));
        $display("test continuous done");
        frame(cmdw(2'h2, s, nb(s), 2'h0));
        frame(cmdw(2'h0, 3'h0, 5'h0, 2'h2));
        rd(`SCB_A_STATUS, v);
        chk({v[1], cont_reg}, 2'b00);
        v = $urandom;
        wr(`SCB_A_WDATA, v, `SCB_RESP_OKAY);
        frame(cmdw(2'h0, 3'h2, nb(3'h2), 2'h0));
        chk(wr_word_reg, msk(v[23:0], nb(3'h2)));
        $display("test resync done");
        wrap_up();
    end

    // a hang counts as a mismatch and ends the run the normal way
    initial begin
        repeat (50000) @(posedge aclk);
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
